// file: hw/scs_sequencer.sv
// Serial configuration sequencer: active and passive serial loading,
// handshake lines and post-load initialization.
// Pins arrive asynchronously and are synchronised to clk here; open-drain
// lines are resolved outside from the oe_n signals.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module scs_sequencer #(
  parameter int STATUS_MIN = scs_pkg::STATUS_MIN_CYC,
  parameter int STATUS_MAX = scs_pkg::STATUS_MAX_CYC,
  parameter int INIT_OSC = scs_pkg::INIT_OSC_CYC,
  parameter int USR_INIT = scs_pkg::USR_INIT_CYC,
  parameter int POR_LEN = scs_pkg::POR_CYC,
  parameter int CNT_W = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire scs_pkg::scs_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  // Handshake pins
  input wire logic config_request_low,
  input wire logic cfg_state_line_low_i,
  output logic cfg_state_line_low_o,
  output logic cfg_state_line_low_oe_n,
  input wire logic load_complete_flag_i,
  output logic load_complete_flag_o,
  output logic load_complete_flag_oe_n,
  output logic init_done_o,
  output logic init_done_oe_n,
  // Shift clock and data pins
  input wire logic config_shift_clock_i,
  output logic config_shift_clock_o,
  output logic config_shift_clock_oe_n,
  output logic active_serial_io_o,
  output logic active_serial_io_oe_n,
  input wire logic [3:0] active_quad_bus,
  input wire logic passive_serial_input,
  input wire logic user_startup_clock,
  // Loaded image and user view
  output scs_pkg::scs_cfg_beat_t cfg_beat,
  output logic user_io_q
);

  localparam int SYNC_W = 9;
  localparam logic [SYNC_W-1:0] SYNC_RST = 9'h1ff;

  scs_pkg::scs_ctrl_t ctrl_q;
  scs_pkg::scs_state_t state_q;
  scs_pkg::scs_state_t state_d;
  logic [31:0] len_q;
  logic [31:0] bits_q;
  logic [31:0] rdata_q;
  logic [CNT_W-1:0] cnt_q;
  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic sclk_prev_q;
  logic uclk_prev_q;
  logic req_hi;
  logic ps_rise;
  logic ps_fall;
  logic usr_rise;
  logic [3:0] half_q;
  logic [3:0] div_q;
  logic sclk_q;
  logic as_run;
  logic fall_en;
  logic cap_en;
  logic [2:0] step;
  logic last_beat;
  logic [3:0] beat;
  logic [31:0] cmd_q;
  logic cnt_inc;
  scs_pkg::scs_cfg_beat_t beat_q;

  // Shift-clock half period in core cycles for a rate setting
  function automatic logic [3:0] half_of(input logic [1:0] fsel,
                                         input logic multi);
    logic [1:0] f;
    int freq;
    f = (multi && fsel == scs_pkg::FSEL_TOP) ? 2'h2 : fsel;
    case (f)
      2'h0: freq = scs_pkg::F_SLOW;
      2'h1: freq = scs_pkg::F_MID;
      2'h2: freq = scs_pkg::F_FAST;
      default: freq = scs_pkg::F_TOP;
    endcase
    half_of = 4'((scs_pkg::CLK_MHZ * 10) / (2 * freq));
  endfunction

  // Any state that belongs to loading or initialization
  function automatic logic configuring(input scs_pkg::scs_state_t s);
    configuring = (s == scs_pkg::ST_CMD) || (s == scs_pkg::ST_LOAD) ||
                  (s == scs_pkg::ST_TAIL) || (s == scs_pkg::ST_CU) ||
                  (s == scs_pkg::ST_INIT);
  endfunction

  // Synchronisers; the first stage is read by the second stage only
  assign async_in = {config_request_low, cfg_state_line_low_i,
                     config_shift_clock_i, passive_serial_input,
                     user_startup_clock, active_quad_bus};

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sync1_q[g] <= SYNC_RST[g];
          sync2_q[g] <= SYNC_RST[g];
        end else begin
          sync1_q[g] <= async_in[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Match the synchroniser reset so no false rising edge follows reset
      sclk_prev_q <= SYNC_RST[6];
      uclk_prev_q <= SYNC_RST[4];
    end else begin
      sclk_prev_q <= sync2_q[6];
      uclk_prev_q <= sync2_q[4];
    end
  end

  assign req_hi = sync2_q[8];
  assign ps_rise = sync2_q[6] && !sclk_prev_q;
  assign ps_fall = !sync2_q[6] && sclk_prev_q;
  assign usr_rise = sync2_q[4] && !uclk_prev_q;

  // Register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= scs_pkg::CTRL_RST;
      len_q <= scs_pkg::LEN_RST;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        scs_pkg::CTRL_ADDR: ctrl_q <= reg_req.wdata[7:0];
        scs_pkg::LEN_ADDR: len_q <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Register reads; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        scs_pkg::CTRL_ADDR: rdata_q <= {24'h0, ctrl_q};
        scs_pkg::LEN_ADDR: rdata_q <= len_q;
        scs_pkg::STAT_ADDR: rdata_q <= {29'h0, state_q};
        scs_pkg::BITS_ADDR: rdata_q <= bits_q;
        default: rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign reg_rdata = rdata_q;

  // Active shift clock divider; rate latched while in ST_RESET
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      half_q <= 4'h8;
    end else if (state_q == scs_pkg::ST_RESET) begin
      half_q <= half_of(ctrl_q.fsel, ctrl_q.multi);
    end
  end

  assign as_run = !ctrl_q.ps &&
                  (state_q == scs_pkg::ST_CMD || state_q == scs_pkg::ST_LOAD);

  always_ff @(posedge clk) begin
    if (!rst_n || !as_run) begin
      div_q <= 4'h0;
      sclk_q <= 1'b0;
    end else if (div_q == half_q - 4'h1) begin
      div_q <= 4'h0;
      sclk_q <= !sclk_q;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign fall_en = as_run && sclk_q && (div_q == half_q - 4'h1);

  // Main sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      scs_pkg::ST_POR: begin
        if (cnt_q >= CNT_W'(POR_LEN - 1)) begin
          state_d = scs_pkg::ST_RESET;
        end
      end
      scs_pkg::ST_RESET: begin
        if (req_hi && cnt_q >= CNT_W'(STATUS_MIN - 1)) begin
          state_d = ctrl_q.ps ? scs_pkg::ST_LOAD : scs_pkg::ST_CMD;
        end
      end
      scs_pkg::ST_CMD: begin
        if (fall_en && cnt_q == CNT_W'(scs_pkg::CMD_BITS - 1)) begin
          state_d = scs_pkg::ST_LOAD;
        end
      end
      scs_pkg::ST_LOAD: begin
        if (cap_en && last_beat) begin
          if (ctrl_q.ps) begin
            state_d = scs_pkg::ST_TAIL;
          end else begin
            state_d = ctrl_q.usrclk ? scs_pkg::ST_CU : scs_pkg::ST_INIT;
          end
        end
      end
      scs_pkg::ST_TAIL: begin
        if (ps_fall && cnt_q == CNT_W'(scs_pkg::TAIL_FALLS - 1)) begin
          state_d = ctrl_q.usrclk ? scs_pkg::ST_CU : scs_pkg::ST_INIT;
        end
      end
      scs_pkg::ST_CU: begin
        if (cnt_q >= CNT_W'(scs_pkg::CD2CU_CYC - 1)) begin
          state_d = scs_pkg::ST_INIT;
        end
      end
      scs_pkg::ST_INIT: begin
        if (ctrl_q.usrclk) begin
          if (usr_rise && cnt_q == CNT_W'(USR_INIT - 1)) begin
            state_d = scs_pkg::ST_USER;
          end
        end else if (cnt_q >= CNT_W'(INIT_OSC - 1)) begin
          state_d = scs_pkg::ST_USER;
        end
      end
      scs_pkg::ST_USER: state_d = scs_pkg::ST_USER;
      default: state_d = scs_pkg::ST_POR;
    endcase
    // Power-on delay is not cut short by the request line
    if (state_q != scs_pkg::ST_POR && !req_hi) begin
      state_d = scs_pkg::ST_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= scs_pkg::ST_POR;
    end else begin
      state_q <= state_d;
    end
  end

  // Shared counter: cycles, shift edges or user clock edges
  always_comb begin
    case (state_q)
      scs_pkg::ST_CMD: cnt_inc = fall_en;
      scs_pkg::ST_TAIL: cnt_inc = ps_fall;
      scs_pkg::ST_INIT: cnt_inc = ctrl_q.usrclk ? usr_rise : 1'b1;
      default: cnt_inc = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n || state_d != state_q) begin
      cnt_q <= '0;
    end else if (cnt_inc && cnt_q != '1) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Flash read command, shifted on falling shift clock edges
  always_ff @(posedge clk) begin
    if (!rst_n || state_q == scs_pkg::ST_RESET) begin
      cmd_q <= {scs_pkg::READ_CMD, scs_pkg::START_ADDR};
    end else if (state_q == scs_pkg::ST_CMD && fall_en) begin
      cmd_q <= {cmd_q[30:0], 1'b0};
    end
  end

  // Image capture
  assign cap_en = state_q == scs_pkg::ST_LOAD &&
                  (ctrl_q.ps ? ps_rise : fall_en);
  assign step = (!ctrl_q.ps && ctrl_q.quad) ? 3'h4 : 3'h1;
  assign last_beat = ({1'b0, bits_q} + {30'h0, step}) >= {1'b0, len_q};

  always_comb begin
    if (ctrl_q.ps) begin
      beat = {3'h0, sync2_q[5]};
    end else if (ctrl_q.quad) begin
      beat = sync2_q[3:0];
    end else begin
      beat = {3'h0, sync2_q[1]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || state_q == scs_pkg::ST_RESET) begin
      bits_q <= 32'h0;
      beat_q <= '0;
    end else begin
      beat_q.valid <= cap_en;
      if (cap_en) begin
        bits_q <= bits_q + {29'h0, step};
        beat_q.data <= beat;
      end
    end
  end

  assign cfg_beat = beat_q;

  // Passive data pin as user input after loading
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      user_io_q <= 1'b0;
    end else begin
      user_io_q <= state_q == scs_pkg::ST_USER && ctrl_q.dual_user &&
                   sync2_q[5];
    end
  end

  // Pin drivers; open-drain lines only ever pull low
  assign cfg_state_line_low_o = 1'b0;
  assign cfg_state_line_low_oe_n = !(state_q == scs_pkg::ST_POR ||
                                     state_q == scs_pkg::ST_RESET);
  assign load_complete_flag_o = 1'b0;
  assign load_complete_flag_oe_n = !(state_q == scs_pkg::ST_POR ||
                                     state_q == scs_pkg::ST_RESET ||
                                     state_q == scs_pkg::ST_CMD ||
                                     state_q == scs_pkg::ST_LOAD);
  assign init_done_o = 1'b0;
  assign init_done_oe_n = !(ctrl_q.initdone_en && configuring(state_q));
  assign config_shift_clock_o = sclk_q;
  assign config_shift_clock_oe_n = ctrl_q.ps;
  assign active_serial_io_o = cmd_q[31];
  // Quad mode turns the command line round to carry data
  assign active_serial_io_oe_n = ctrl_q.ps || !(state_q == scs_pkg::ST_CMD ||
    (state_q == scs_pkg::ST_LOAD && !ctrl_q.quad));

  // Checks
  logic [CNT_W-1:0] hi_cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n || state_q != scs_pkg::ST_RESET || !req_hi) begin
      hi_cnt_q <= '0;
    end else if (hi_cnt_q != '1) begin
      hi_cnt_q <= hi_cnt_q + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_req_pull;
    $fell(req_hi) && state_q != scs_pkg::ST_POR |=>
      state_q == scs_pkg::ST_RESET && !cfg_state_line_low_oe_n &&
      !load_complete_flag_oe_n;
  endproperty
  a_req_pull: assert property (p_req_pull)
    else $error("request fall did not pull both lines low");

  property p_por_low;
    state_q == scs_pkg::ST_POR |-> !cfg_state_line_low_oe_n;
  endproperty
  a_por_low: assert property (p_por_low)
    else $error("status released during power-on delay");

  property p_flag_low;
    (state_q == scs_pkg::ST_LOAD || state_q == scs_pkg::ST_CMD) |->
      !load_complete_flag_oe_n;
  endproperty
  a_flag_low: assert property (p_flag_low)
    else $error("load-complete flag released during loading");

  property p_status_min;
    $rose(cfg_state_line_low_oe_n) |->
      $past(cnt_q) >= CNT_W'(STATUS_MIN - 1);
  endproperty
  a_status_min: assert property (p_status_min)
    else $error("status low pulse too short");

  property p_status_max;
    state_q == scs_pkg::ST_RESET |-> hi_cnt_q <= CNT_W'(STATUS_MAX);
  endproperty
  a_status_max: assert property (p_status_max)
    else $error("status released too late after request rise");

  property p_no_top_chain;
    as_run && ctrl_q.multi |-> half_q != half_of(scs_pkg::FSEL_TOP, 1'b0);
  endproperty
  a_no_top_chain: assert property (p_no_top_chain)
    else $error("fastest shift clock used with chained devices");

  property p_cu_wait;
    state_q == scs_pkg::ST_CU && state_d == scs_pkg::ST_INIT |->
      cnt_q == CNT_W'(scs_pkg::CD2CU_CYC - 1);
  endproperty
  a_cu_wait: assert property (p_cu_wait)
    else $error("user clock enabled too early");

  property p_cmd_fall;
    state_q == scs_pkg::ST_CMD && $past(state_q) == scs_pkg::ST_CMD &&
      $changed(active_serial_io_o) |-> $past(fall_en);
  endproperty
  a_cmd_fall: assert property (p_cmd_fall)
    else $error("command line changed off a falling edge");

  property p_as_capture;
    cfg_beat.valid && !ctrl_q.ps |-> $past(fall_en);
  endproperty
  a_as_capture: assert property (p_as_capture)
    else $error("flash data captured off a falling edge");

  property p_user_lines;
    state_q == scs_pkg::ST_USER && req_hi |->
      cfg_state_line_low_oe_n && load_complete_flag_oe_n && init_done_oe_n;
  endproperty
  a_user_lines: assert property (p_user_lines)
    else $error("a handshake line is low in user mode");

  property p_tail_two;
    state_q == scs_pkg::ST_TAIL ##1 state_q != scs_pkg::ST_TAIL &&
      state_q != scs_pkg::ST_RESET |-> $past(cnt_q) == CNT_W'(1);
  endproperty
  a_tail_two: assert property (p_tail_two)
    else $error("initialization started without two falling edges");

  property p_init_done_low;
    ctrl_q.initdone_en && state_q == scs_pkg::ST_INIT |-> !init_done_oe_n;
  endproperty
  a_init_done_low: assert property (p_init_done_low)
    else $error("init-done released before user mode");

  c_user: cover property (state_q == scs_pkg::ST_INIT ##1
                          state_q == scs_pkg::ST_USER);
  c_ps_tail: cover property (state_q == scs_pkg::ST_TAIL ##1
                             state_q == scs_pkg::ST_CU);
  c_quad: cover property (cfg_beat.valid && ctrl_q.quad && !ctrl_q.ps);

endmodule

// file: pkg/scs_pkg.sv
// Constants, register map and carrier types of the serial config sequencer.
// Assumes a 200 MHz core clock and a plain strobe-based register port.
//
// Overview of operation
// - Quad active link moves four bits per shift clock
// - Active shift clock offers four rate settings
// - Chained devices never get the fastest rate
// - Command line changes on shift clock falling edge
// - Flash data captured on shift clock falling edge
// - Oscillator init reaches user mode in 175-437 us
// - User clock start waits, then 8576 cycles
// - Init clock: internal oscillator or user clock
// - Enabled init-done pin held low until init ends
// - User mode: all lines high; request low restarts
// - Status line held low during power-on delay
// - Load-complete flag low before and during loading
// - Flag released only after whole image received
// - Passive data pin becomes user I/O afterwards
// - Request fall pulls flag and status low quickly
// - Status held low 268 to 1506 us
// - Status released within 1506 us of request rise
// - Passive data sampled on host clock rising edges
// - Active handshake timing equals passive timing
package scs_pkg;

  localparam int CLK_MHZ = 200;

  // Register port
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] LEN_ADDR = 4'h4;
  localparam logic [3:0] STAT_ADDR = 4'h8;
  localparam logic [3:0] BITS_ADDR = 4'hc;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] LEN_RST = 32'h0000_0100;

  // Shift clock settings, in units of 100 kHz
  localparam int F_SLOW = 125;
  localparam int F_MID = 250;
  localparam int F_FAST = 500;
  localparam int F_TOP = 1000;
  localparam int F_SLOW_MIN = 53;
  localparam logic [1:0] FSEL_TOP = 2'h3;

  // Handshake and initialization times
  localparam int T_STATUS_MIN_US = 268;
  localparam int T_STATUS_MAX_US = 1506;
  localparam int T_CD2UM_MIN_US = 175;
  localparam int T_CD2UM_MAX_US = 437;
  localparam int STATUS_MIN_CYC = T_STATUS_MIN_US * CLK_MHZ;
  localparam int STATUS_MAX_CYC = T_STATUS_MAX_US * CLK_MHZ;
  localparam int INIT_OSC_CYC = T_CD2UM_MIN_US * CLK_MHZ;
  localparam int INIT_OSC_MAX_CYC = T_CD2UM_MAX_US * CLK_MHZ;
  // Four periods of the slowest shift clock, rounded up
  localparam int CD2CU_CYC =
    (4 * 10000 * CLK_MHZ + F_SLOW_MIN * 1000 - 1) / (F_SLOW_MIN * 1000);
  localparam int USR_INIT_CYC = 8576;
  localparam int POR_CYC = 1024;
  localparam int TAIL_FALLS = 2;

  // Flash read sequence
  localparam int CMD_BITS = 32;
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [23:0] START_ADDR = 24'h00_0000;

  typedef struct packed {
    logic initdone_en;
    logic dual_user;
    logic usrclk;
    logic multi;
    logic [1:0] fsel;
    logic quad;
    logic ps;
  } scs_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } scs_reg_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] data;
  } scs_cfg_beat_t;

  typedef enum logic [2:0] {
    ST_POR, ST_RESET, ST_CMD, ST_LOAD, ST_TAIL, ST_CU, ST_INIT, ST_USER
  } scs_state_t;

endpackage

// file: verification/scs_host_model.sv
// Far side model: passive serial host and serial flash.
// Assumes the bench pulses go only while the device waits for data.
`timescale 1ns/1ps
module scs_host_model (
  // Bench control
  input wire logic go,
  input wire logic [31:0] pattern,
  input wire logic [5:0] nbits,
  input wire logic req_low,
  input wire logic [3:0] nib,
  // Device pins
  input wire logic config_shift_clock_o,
  output logic config_shift_clock_i,
  output logic passive_serial_input,
  output logic [3:0] active_quad_bus
);
  int rises;

  initial begin
    config_shift_clock_i = 1'b0;
    passive_serial_input = 1'b0;
    active_quad_bus = 4'h5;
    rises = 0;
  end

  // Off the core clock grid, so no edge races with the sampler
  always @(posedge go) begin
    #0.3;
    for (int i = 0; i < nbits; i++) begin
      passive_serial_input = pattern[i];
      #16 config_shift_clock_i = 1'b1;
      #32 config_shift_clock_i = 1'b0;
      #16;
    end
    passive_serial_input = ~passive_serial_input;
    repeat (2) begin
      #32 config_shift_clock_i = 1'b1;
      #32 config_shift_clock_i = 1'b0;
    end
  end

  // Flash: command phase junk, then a steady nibble past each fall
  always @(posedge config_shift_clock_o or negedge req_low) begin
    if (!req_low) rises = 0;
    else rises++;
    if (rises > 32) active_quad_bus = nib;
    else active_quad_bus = ~active_quad_bus;
  end
endmodule

// file: verification/test_scs_sequencer.sv
// Self-checking bench of the serial config sequencer, shortened counts.
// Assumes the package, the design and the host model compile first.
`timescale 1ns/1ps
module test_scs_sequencer;
  localparam int POR_N = 16;
  localparam int ST_MIN = 40;
  localparam int ST_MAX = 200;
  localparam int INIT_N = 30;
  localparam int INIT_HI = INIT_N * 437 / 175;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  scs_pkg::scs_reg_req_t reg_req = '0;
  logic [31:0] reg_rdata;
  logic req_low = 1'b1;
  logic st_o, st_oe_n, fl_o, fl_oe_n, id_o, id_oe_n;
  logic sck_i, sck_o, sck_oe_n, io_o, io_oe_n, psi, user_io;
  logic usr_clk = 1'b0;
  logic go = 1'b0;
  logic [3:0] quad;
  logic [3:0] nib = 4'h0;
  logic [5:0] nbits = 6'h0;
  logic [31:0] pat = 32'h0;
  logic [31:0] rng = 32'h1642e7f4;
  logic [31:0] cmd_q = 32'h0;
  logic sck_d = 1'b0;
  logic io_d = 1'b0;
  logic fl_d = 1'b0;
  scs_pkg::scs_cfg_beat_t beat;
  logic [3:0] beats[$];
  int error_cnt = 0;
  int checks_done = 0;
  int per = 0;
  int last_per = 0;
  int nrise = 0;
  int bad_edge = 0;
  int rel_cnt = 0;

  scs_sequencer #(.STATUS_MIN(ST_MIN), .STATUS_MAX(ST_MAX),
    .INIT_OSC(INIT_N), .USR_INIT(20), .POR_LEN(POR_N)) i_scs_sequencer (
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .config_request_low(req_low),
    .cfg_state_line_low_i(st_oe_n ? 1'b1 : st_o),
    .cfg_state_line_low_o(st_o), .cfg_state_line_low_oe_n(st_oe_n),
    .load_complete_flag_i(fl_oe_n ? 1'b1 : fl_o),
    .load_complete_flag_o(fl_o), .load_complete_flag_oe_n(fl_oe_n),
    .init_done_o(id_o), .init_done_oe_n(id_oe_n),
    .config_shift_clock_i(sck_i), .config_shift_clock_o(sck_o),
    .config_shift_clock_oe_n(sck_oe_n), .active_serial_io_o(io_o),
    .active_serial_io_oe_n(io_oe_n), .active_quad_bus(quad),
    .passive_serial_input(psi), .user_startup_clock(usr_clk),
    .cfg_beat(beat), .user_io_q(user_io));

  scs_host_model i_scs_host_model (.go(go), .pattern(pat), .nbits(nbits),
    .req_low(req_low), .nib(nib), .config_shift_clock_o(sck_o),
    .config_shift_clock_i(sck_i), .passive_serial_input(psi),
    .active_quad_bus(quad));

  initial forever #2.5 clk = ~clk;
  initial forever #7 usr_clk = ~usr_clk;

  function automatic logic [31:0] xs(logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Watches shift clock, command bits, beats and the flag release
  always @(posedge clk) begin
    sck_d <= sck_o;
    io_d <= io_o;
    fl_d <= fl_oe_n;
    if (sck_o && !sck_d) begin
      last_per <= per;
      per <= 1;
      if (nrise < 32) cmd_q <= {cmd_q[30:0], io_o};
      nrise <= nrise + 1;
    end else per <= per + 1;
    if (io_o !== io_d && sck_o && sck_d) bad_edge <= bad_edge + 1;
    if (beat.valid === 1'b1) beats.push_back(beat.data);
    if (fl_oe_n && !fl_d) rel_cnt <= beats.size();
  end

  task automatic run(scs_pkg::scs_ctrl_t c, int len);
    int n;
    int tot;
    logic [31:0] d;
    wr(scs_pkg::CTRL_ADDR, {24'h0, c});
    wr(scs_pkg::LEN_ADDR, len);
    @(posedge clk);
    req_low <= 1'b0;
    for (n = 0; n < 200 && (st_oe_n !== 1'b0 || fl_oe_n !== 1'b0); n++)
      @(posedge clk);
    chk(n <= 120, 1);
    repeat (400) @(posedge clk);
    beats.delete();
    nrise = 0;
    bad_edge = 0;
    req_low <= 1'b1;
    for (n = 0; n < 2 * ST_MAX && st_oe_n !== 1'b1; n++) @(posedge clk);
    chk(n <= ST_MAX, 1);
    tot = c.quad ? len / 4 : len;
    if (c.ps) begin
      tot = len;
      repeat (400) @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
    end
    for (n = 0; n < 20000 && fl_oe_n !== 1'b1; n++) @(posedge clk);
    for (n = 0; n < 2000 && id_oe_n !== 1'b1; n++) @(posedge clk);
    if (c.usrclk) chk(n >= scs_pkg::CD2CU_CYC && n < 2000, 1);
    else chk(n >= INIT_N && n <= INIT_HI, 1);
    repeat (4) @(posedge clk);
    rd(scs_pkg::STAT_ADDR, d);
    chk(d, 32'h7);
    rd(scs_pkg::BITS_ADDR, d);
    chk(d, len);
    chk({st_oe_n, fl_oe_n}, 2'b11);
    chk(beats.size(), tot);
    chk(rel_cnt, tot);
    chk(bad_edge, 0);
    foreach (beats[i]) begin
      if (c.ps) chk(beats[i][0], pat[i]);
      else if (c.fsel == 2'h0)
        chk(c.quad ? beats[i] : beats[i][0], c.quad ? nib : nib[1]);
    end
    if (!c.ps) begin
      chk(cmd_q, {scs_pkg::READ_CMD, scs_pkg::START_ADDR});
      chk(last_per, 16 >> ((c.multi && c.fsel == 2'h3) ? 2 : c.fsel));
    end
    chk(user_io, c.dual_user ? psi : 1'b0);
  endtask

  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end

  initial begin
    int n;
    logic [31:0] d;
    scs_pkg::scs_ctrl_t c;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({st_oe_n, fl_oe_n}, 2'b00);
    for (n = 1; n < 1000 && st_oe_n !== 1'b1; n++) @(posedge clk);
    chk(n >= POR_N + ST_MIN && n <= POR_N + ST_MAX + 2, 1);
    rd(scs_pkg::CTRL_ADDR, d);
    chk(d, {24'h0, scs_pkg::CTRL_RST});
    rd(scs_pkg::LEN_ADDR, d);
    chk(d, scs_pkg::LEN_RST);
    rd(4'h2, d);
    chk(d, 32'h0);
    // Mix of passive, user-clock and every active rate, multi at the top
    for (int k = 0; k < 8; k++) begin
      rng = xs(rng);
      c = scs_pkg::scs_ctrl_t'(rng[7:0]);
      c.initdone_en = 1'b1;
      c.ps = k < 3;
      c.usrclk = k == 1 || k == 5;
      c.fsel = k[1:0];
      c.multi = k == 7 ? 1'b1 : c.multi;
      pat <= xs(rng);
      nib <= rng[11:8];
      nbits <= k == 2 ? 6'd1 : 6'd8 + 6'(rng[12:9]);
      @(posedge clk);
      run(c, c.ps ? int'(nbits) : 32);
    end
    finish_test();
  end
endmodule
